// file: rtl/jtag_emulation_test_port.sv
// test and emulation access port, sampled on mclk
`timescale 1ns/1ps
// How it works
// R1: tdo updates only on test clock falls
// R2: tdo released except while shifting
// R3: tdi sampled on test clock rise
// R4: tms steers tap on rising edges
// R5: tester supplies free-running test clock; emu_model toggles tck only in its clk task, parked low between
// R6: test reset high enables test logic
// R7: test reset low ignores all test inputs
// R8: tester pulses test reset low once; the bench pulses trst_n low twice, once near the end of each scan loop pass
// R9: event pin one is bidirectional interrupt
// R10: pull-inhibit register gates pin pulls
// R11: tap select latched at test reset rise
// R12: sixteen-state tap, reset while trst low
module jtag_emulation_test_port
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	output logic tdo_o,
	output logic tdo_oe_n,
	input wire logic emulator_tap_select_pin_i,
	input wire logic emulator_event_pin_1_i,
	output logic emulator_event_pin_1_o,
	output logic emulator_event_pin_1_oe_n,
	output logic emu_event_in,
	input wire logic emu_event_out,
	output logic emulation_tap_sel,
	output logic test_active,
	output logic [tap_pkg::pull_w-1:0] pull_inhibit_control
);
	import tap_pkg::*;

	// synchronised pins
	logic tck_rise, tck_fall; // only the test clock edges are used
	logic tms_s, tdi_s, trst_s, trst_rise, sel_s, evt_s;
	pin_sync u_tck (.mclk(mclk), .arst_n(arst_n), .pin(tck), .level(), .rise(tck_rise), .fall(tck_fall));
	pin_sync u_tms (.mclk(mclk), .arst_n(arst_n), .pin(tms), .level(tms_s), .rise(), .fall());
	pin_sync u_tdi (.mclk(mclk), .arst_n(arst_n), .pin(tdi), .level(tdi_s), .rise(), .fall());
	pin_sync u_trst (.mclk(mclk), .arst_n(arst_n), .pin(trst_n), .level(trst_s), .rise(trst_rise), .fall());
	pin_sync u_sel (.mclk(mclk), .arst_n(arst_n), .pin(emulator_tap_select_pin_i), .level(sel_s), .rise(),
		.fall());
	pin_sync u_evt (.mclk(mclk), .arst_n(arst_n), .pin(emulator_event_pin_1_i), .level(evt_s), .rise(),
		.fall());

	tap_state_t state_q, state_d; // tap controller
	logic [ir_w-1:0] ir_sh_q, ir_q; // instruction shift and hold
	logic [31:0] dr_sh_q; // data shift chain
	logic [pull_w-1:0] pull_q; // pull-inhibit control
	logic [emu_w-1:0] emu_q; // emulator event control
	logic tdo_q, tdo_oe_n_q, sel_q, evt_o_q, evt_oe_n_q, evt_in_q, active_q;

	// next tap state from tms, standard graph
	function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
		case (s)
			st_reset: tap_next = m ? st_reset : st_idle;
			st_idle: tap_next = m ? st_sel_dr : st_idle;
			st_sel_dr: tap_next = m ? st_sel_ir : st_cap_dr;
			st_cap_dr: tap_next = m ? st_ex1_dr : st_shift_dr;
			st_shift_dr: tap_next = m ? st_ex1_dr : st_shift_dr;
			st_ex1_dr: tap_next = m ? st_upd_dr : st_pause_dr;
			st_pause_dr: tap_next = m ? st_ex2_dr : st_pause_dr;
			st_ex2_dr: tap_next = m ? st_upd_dr : st_shift_dr;
			st_upd_dr: tap_next = m ? st_sel_dr : st_idle;
			st_sel_ir: tap_next = m ? st_reset : st_cap_ir;
			st_cap_ir: tap_next = m ? st_ex1_ir : st_shift_ir;
			st_shift_ir: tap_next = m ? st_ex1_ir : st_shift_ir;
			st_ex1_ir: tap_next = m ? st_upd_ir : st_pause_ir;
			st_pause_ir: tap_next = m ? st_ex2_ir : st_pause_ir;
			st_ex2_ir: tap_next = m ? st_upd_ir : st_shift_ir;
			st_upd_ir: tap_next = m ? st_sel_dr : st_idle;
			default: tap_next = st_reset;
		endcase
	endfunction

	// decode of current state and instruction
	wire test_on = trst_s; // [R6] [R7]
	wire shift_dr = (state_q == st_shift_dr);
	wire shift_ir = (state_q == st_shift_ir);
	wire scanning = shift_dr | shift_ir;
	wire is_pull = (ir_q == ir_pull);
	wire is_emu = (ir_q == ir_emu_event);
	wire is_id = (ir_q == ir_idcode);
	// any other code falls through to the one-bit bypass chain
	// tail bit of the selected data register
	wire dr_tail = dr_sh_q[0]; // every chain empties from bit zero
	wire tdo_bit = shift_ir ? ir_sh_q[0] : dr_tail;
	// shift-in position depends on register length
	wire [31:0] dr_shifted = is_id ? {tdi_s, dr_sh_q[31:1]} :
		is_pull ? {27'h0, tdi_s, dr_sh_q[pull_w-1:1]} :
		is_emu ? {30'h0, tdi_s, dr_sh_q[emu_w-1:1]} : {31'h0, tdi_s};
	wire [31:0] dr_capture = is_id ? idcode_val : is_pull ? {27'h0, pull_q} :
		is_emu ? {30'h0, evt_s, emu_q[emu_oe_bit]} : 32'h0;

	always_comb
	begin
		state_d = test_on ? tap_next(state_q, tms_s) : st_reset; // [R4] [R12]
	end

	// tap state and registers advance on test clock rise
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			state_q <= st_reset;
		else if (!test_on)
			state_q <= st_reset; // [R12]
		else if (tck_rise)
			state_q <= state_d; // [R4]
	end

	// instruction shift and update
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ir_sh_q <= ir_capture_val;
			ir_q <= ir_reset_val;
		end
		else if (!test_on || state_q == st_reset)
			ir_q <= ir_reset_val; // [R7]
		else if (tck_rise)
		begin
			if (state_q == st_cap_ir)
				ir_sh_q <= ir_capture_val;
			else if (shift_ir)
				ir_sh_q <= {tdi_s, ir_sh_q[ir_w-1:1]}; // [R3]
			else if (state_q == st_upd_ir)
				ir_q <= ir_sh_q;
		end
	end

	// data chain capture and shift
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			dr_sh_q <= 32'h0;
		else if (test_on && tck_rise)
		begin
			if (state_q == st_cap_dr)
				dr_sh_q <= dr_capture;
			else if (shift_dr)
				dr_sh_q <= dr_shifted; // [R3] [R4]
		end
	end

	// pull-inhibit and event control update
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pull_q <= pull_reset_val;
			emu_q <= emu_reset_val;
		end
		else if (test_on && tck_rise && state_q == st_upd_dr)
		begin
			if (is_pull)
				pull_q <= dr_sh_q[pull_w-1:0]; // [R10]
			if (is_emu)
				emu_q <= dr_sh_q[emu_w-1:0]; // [R9]
		end
	end

	// tdo changes on test clock fall only
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tdo_q <= 1'b0;
			tdo_oe_n_q <= 1'b1;
		end
		else if (!test_on)
			tdo_oe_n_q <= 1'b1; // [R2] [R7]
		else if (tck_fall)
		begin
			tdo_q <= tdo_bit; // [R1]
			tdo_oe_n_q <= ~scanning; // [R2]
		end
	end

	// tap select latched when test reset rises
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			sel_q <= 1'b0;
		else if (trst_rise)
			sel_q <= sel_s; // [R11]
	end

	// event pin one: drive or sense per emulation control
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			evt_o_q <= 1'b0;
			evt_oe_n_q <= 1'b1;
			evt_in_q <= 1'b0;
			active_q <= 1'b0;
		end
		else
		begin
			evt_o_q <= emu_q[emu_val_bit] | emu_event_out; // [R9]
			evt_oe_n_q <= ~(test_on & emu_q[emu_oe_bit]); // [R9]
			evt_in_q <= evt_s & ~emu_q[emu_oe_bit]; // [R9]
			active_q <= test_on; // [R6]
		end
	end

	assign tdo_o = tdo_q;
	assign tdo_oe_n = tdo_oe_n_q;
	assign emulator_event_pin_1_o = evt_o_q;
	assign emulator_event_pin_1_oe_n = evt_oe_n_q;
	assign emu_event_in = evt_in_q;
	assign emulation_tap_sel = sel_q;
	assign test_active = active_q;
	assign pull_inhibit_control = pull_q;
endmodule

// file: rtl/tap_pkg.sv
// constants and types shared by the test access port design
package tap_pkg;
	// tap controller states, standard sixteen-state machine
	typedef enum logic [3:0] {
		st_reset, st_idle, st_sel_dr, st_cap_dr, st_shift_dr, st_ex1_dr, st_pause_dr, st_ex2_dr, st_upd_dr,
		st_sel_ir, st_cap_ir, st_shift_ir, st_ex1_ir, st_pause_ir, st_ex2_ir, st_upd_ir
	} tap_state_t;
	// instruction register width and codes
	localparam int ir_w = 4;
	localparam logic [3:0] ir_capture_val = 4'h1;
	localparam logic [3:0] ir_bypass = 4'hf;
	localparam logic [3:0] ir_idcode = 4'h2;
	localparam logic [3:0] ir_pull = 4'h3;
	localparam logic [3:0] ir_emu_event = 4'h4;
	localparam logic [3:0] ir_reset_val = 4'hf;
	// identification word, value is arbitrary
	localparam logic [31:0] idcode_val = 32'h0000_0001;
	// pull-inhibit control bits: tck, tms, tdi, emulator_tap_select_pin, emulator_event_pin_1
	localparam int pull_w = 5;
	localparam logic [4:0] pull_reset_val = 5'h00;
	// emulator event control bits: [0] drive enable, [1] drive value
	localparam int emu_w = 2;
	localparam int emu_oe_bit = 0;
	localparam int emu_val_bit = 1;
	localparam logic [1:0] emu_reset_val = 2'h0;
endpackage

// file: rtl/pin_sync.sv
// two-flop synchroniser with edge detection for pins from outside mclk
`timescale 1ns/1ps
module pin_sync
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic pin,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta_q; // first stage, read only by second
	logic sync_q; // second stage
	logic last_q; // previous synced level

	// two-stage synchroniser plus history flop
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end
		else
		begin
			meta_q <= pin;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise = sync_q & ~last_q; // edge seen on synced level
	assign fall = ~sync_q & last_q;
endmodule

// file: dv/tap_asserts.sv
// assertions on the test port outputs
`timescale 1ns/1ps
module tap_chk
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic tck,
	input wire logic trst_n,
	input wire logic tdo_o,
	input wire logic tdo_oe_n,
	input wire logic emulator_tap_select_pin_i,
	input wire logic emulator_event_pin_1_o,
	input wire logic emulator_event_pin_1_oe_n,
	input wire logic emu_event_out,
	input wire logic emulation_tap_sel,
	input wire logic test_active,
	input wire logic [tap_pkg::pull_w-1:0] pull_inhibit_control
);
	import tap_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	a_tdo_on_fall: assert property (trst_n && $changed(tdo_o) |-> !$past(tck, 2)) else $error("tdo moved");
	a_oe_on_fall: assert property ($fell(tdo_oe_n) |-> !$past(tck, 2)) else $error("oe moved");
	a_oe_idle_reset: assert property (!trst_n [*4] |-> tdo_oe_n) else $error("tdo driven");
	a_func_mode: assert property (!trst_n [*4] |-> !test_active) else $error("active");
	a_test_on: assert property (trst_n [*5] |-> test_active) else $error("inactive");
	a_pull_frozen: assert property (!trst_n [*4] |=> $stable(pull_inhibit_control)) else $error("pull");
	a_evt_released: assert property (!trst_n [*4] |-> emulator_event_pin_1_oe_n) else $error("event driven");
	a_sel_hold: assert property (trst_n [*5] |=> $stable(emulation_tap_sel)) else $error("sel moved");
	a_sel_latch: assert property ($rose(trst_n) |-> ##6 emulation_tap_sel == $past(emulator_tap_select_pin_i, 6))
		else $error("sel");
	a_event_or: assert property (!emulator_event_pin_1_oe_n && $past(emu_event_out) |-> emulator_event_pin_1_o)
		else $error("event");
endmodule
bind jtag_emulation_test_port tap_chk chk_u (.mclk(mclk), .arst_n(arst_n), .tck(tck), .trst_n(trst_n),
	.tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .emulator_tap_select_pin_i(emulator_tap_select_pin_i),
	.emulator_event_pin_1_o(emulator_event_pin_1_o), .emulator_event_pin_1_oe_n(emulator_event_pin_1_oe_n),
	.emu_event_out(emu_event_out), .emulation_tap_sel(emulation_tap_sel), .test_active(test_active),
	.pull_inhibit_control(pull_inhibit_control));

// file: dv/emu_model.sv
// emulator model: test clock driver and pulled-up pins
`timescale 1ns/1ps
module emu_model
(
	input wire logic mclk,
	input wire logic tdo_o,
	input wire logic tdo_oe_n,
	input wire logic ev_o,
	input wire logic ev_oe_n,
	input wire logic em_low,
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic tdo_w,
	output logic ev_w
);
	// released pins float high through pull-ups
	assign tdo_w = tdo_oe_n ? 1'b1 : tdo_o;
	// open-drain style wire, either side may pull low
	assign ev_w = (ev_oe_n | ev_o) & !em_low;
	// test clock parked low, mode and data idle high
	initial {tck, tms, tdi} = 3'b011;
	// one even test clock cycle, low between frames
	task automatic clk(input logic t, input logic d);
		tms <= t;
		tdi <= d;
		repeat (16) @(posedge mclk);
		tck <= 1'b1;
		repeat (16) @(posedge mclk);
		tck <= 1'b0;
	endtask
endmodule

// file: dv/jtag_emulation_test_port_tb.sv
// self-checking bench for the test access port
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fails++; $display("Error %s %h %h", n, e, a); end end
module jtag_emulation_test_port_tb;
	import tap_pkg::*;
	logic mclk, arst_n, trst_n, strap, em_low, ev_out, mon, eb;
	logic tck, tms, tdi, tdo_o, tdo_oe_n, tdo_w, ev_w, ev_o, ev_oe_n, ev_in, sel, act;
	logic [pull_w-1:0] pull;
	logic [31:0] rs;
	logic exp_q[$];
	int fails, num_checks;
	jtag_emulation_test_port dut_u (.mclk(mclk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi),
		.trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .emulator_tap_select_pin_i(strap),
		.emulator_event_pin_1_i(ev_w), .emulator_event_pin_1_o(ev_o), .emulator_event_pin_1_oe_n(ev_oe_n),
		.emu_event_in(ev_in), .emu_event_out(ev_out), .emulation_tap_sel(sel), .test_active(act),
		.pull_inhibit_control(pull));
	emu_model p_u (.mclk(mclk), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .ev_o(ev_o), .ev_oe_n(ev_oe_n),
		.em_low(em_low), .tck(tck), .tms(tms), .tdi(tdi), .tdo_w(tdo_w), .ev_w(ev_w));
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	// note expected tdo bits, lsb first
	task automatic note(input logic [31:0] v, input int n);
		for (int i = 0; i < n; i++)
			exp_q.push_back(v[i]);
	endtask
	// park in idle (leaves reset state), to shift, n bits, update, back to idle
	task automatic scan(input logic ir, input logic [31:0] d, input int n, input logic m);
		p_u.clk(1'b0, 1'b0);
		p_u.clk(1'b1, 1'b0);
		if (ir)
			p_u.clk(1'b1, 1'b0);
		p_u.clk(1'b0, 1'b0);
		p_u.clk(1'b0, 1'b0);
		mon = m;
		for (int i = 0; i < n; i++)
			p_u.clk(i == n - 1, d[i]);
		mon = 1'b0;
		p_u.clk(1'b1, 1'b0);
		p_u.clk(1'b0, 1'b0);
	endtask
	// oldest note against each bit seen at tck rise
	always @(posedge tck)
		if (mon)
		begin
			eb = exp_q.pop_front();
			`CHK("tdo", eb, tdo_w)
		end
	task automatic summarize;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// hang guard
	initial
	begin
		repeat (100000) @(posedge mclk);
		fails++;
		summarize();
	end
	initial
	begin
		{arst_n, trst_n, strap, em_low, ev_out, mon} = 6'h0;
		rs = 32'h3b5c;
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			rs = xs(rs);
			strap <= k[0];
			repeat (8) @(posedge mclk);
			`CHK("act", 1'b0, act)
			trst_n <= 1'b1;
			repeat (8) @(posedge mclk);
			`CHK("sel", k[0], sel)
			`CHK("act", 1'b1, act)
			note(ir_capture_val, ir_w);
			scan(1'b1, ir_idcode, ir_w, 1'b1);
			note(idcode_val, 32);
			scan(1'b0, idcode_val, 32, 1'b1);
			`CHK("oe", 1'b1, tdo_oe_n)
			// bypass: captured zero first, then tdi one bit late
			note(ir_capture_val, ir_w);
			scan(1'b1, ir_bypass, ir_w, 1'b1);
			note(rs << 1, 4);
			scan(1'b0, rs, 4, 1'b1);
			scan(1'b1, ir_pull, ir_w, 1'b0);
			scan(1'b0, rs, pull_w, 1'b0);
			`CHK("pull", rs[pull_w-1:0], pull)
			trst_n <= 1'b0;
			// functional mode: tdo released, pull-up seen
			note(32'hffff_ffff, pull_w);
			scan(1'b0, ~rs, pull_w, 1'b1);
			`CHK("pull", rs[pull_w-1:0], pull)
			$display("test scan %0d done", k);
		end
		trst_n <= 1'b1;
		em_low <= 1'b1;
		repeat (8) @(posedge mclk);
		`CHK("evin", 1'b0, ev_in)
		em_low <= 1'b0;
		repeat (8) @(posedge mclk);
		`CHK("evin", 1'b1, ev_in)
		// strap moves while test reset high: latched select holds
		strap <= 1'b0;
		scan(1'b1, ir_emu_event, ir_w, 1'b0);
		scan(1'b0, 32'h1, emu_w, 1'b0);
		repeat (4) @(posedge mclk);
		`CHK("evoe", 1'b0, ev_oe_n)
		`CHK("evo", 1'b0, ev_o)
		ev_out <= 1'b1;
		repeat (4) @(posedge mclk);
		`CHK("evo", 1'b1, ev_o)
		`CHK("evin", 1'b0, ev_in)
		`CHK("sel", 1'b1, sel)
		$display("test event done");
		summarize();
	end
endmodule
